//--- rtl/scd_cfg.svh
/*
 * Offsets, field positions, reset values and codes of the configuration
 * and diagnostics buffer handshake. Included by the design and the bench.
 */
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH

// Register indices; byte address is four times the index
`define SCD_IDX_DIAG_OWNER 8'h0C
`define SCD_IDX_DIAG_SWAP 8'h0D
`define SCD_IDX_CFG_ACCEPT 8'h10
`define SCD_IDX_CFG_REJECT 8'h11
`define SCD_IDX_MODE_ONE 8'h20
`define SCD_IDX_STATUS 8'h21
`define SCD_IDX_IN_LEN 8'h22
`define SCD_IDX_DIAG1_LEN 8'h23
`define SCD_IDX_DIAG2_LEN 8'h24

// Field positions
`define SCD_MODE_CHG_CFG_BIT 0
`define SCD_STAT_DIAG_FLAG_BIT 0
`define SCD_STAT_CFG_PEND_BIT 1
`define SCD_STAT_STATE_LSB 2
`define SCD_DIAG_STATIC_BIT 1

// Acknowledgement results
`define SCD_ACK_FINISHED 2'h0
`define SCD_ACK_CONFLICT 2'h1
`define SCD_ACK_NOT_ALLOWED 2'h3

// Ownership codes
`define SCD_OWN_NIL 2'h0
`define SCD_OWN_HOST 2'h1
`define SCD_OWN_DEVICE 2'h2
`define SCD_OWN_SENDING 2'h3

// Reset values, empty input length and idle trigger counter
`define SCD_RST_MODE_ONE 8'h00
`define SCD_RST_LEN 8'h00
`define SCD_RST_DIAG1_OWNER 2'h1
`define SCD_RST_DIAG2_OWNER 2'h2
`define SCD_RST_CFG_PTR 2'h0
`define SCD_RST_AUX_PTR 2'h1
`define SCD_RST_RDCFG_PTR 2'h2
`define SCD_IN_LEN_EMPTY 8'h00
`define SCD_TRIG_ZERO 4'h0

`endif

//--- rtl/scd_pkg.sv
/*
 * Types of the configuration and diagnostics buffer handshake.
 * Assumes nothing beyond the constants header.
 */
package scd_pkg;
    typedef enum logic [1:0] {
        SCD_WAIT_PRM,
        SCD_WAIT_CFG,
        SCD_WAIT_DIN,
        SCD_DATA_EXCH
    } scd_slave_e;

    typedef logic [1:0] scd_code_t;
    typedef logic [7:0] scd_byte_t;
endpackage

//--- rtl/scd_cfg_diag_handshake.sv
/*
 * Configuration-check and diagnostics buffer handshake of a fieldbus slave,
 * with an AHB-Lite register slave (zero wait states, always OKAY).
 * Assumes telegram events, counters and the buffer RAM come from logic on
 * clk_sys; events are one-cycle pulses qualified by clkEn.
 */
// Behaviour
// - Valid config telegram: swap buffers, length, interrupt
// - Accept or reject clears config interrupt
// - Reject: diagnostic bits update, back to parameters
// - Accept: exchange now only if empty, counters zero
// - Entering data exchange raises enter/leave interrupt
// - Enabled: accept swaps config and read-config
// - Second telegram before ack returns conflict
// - Reads at 10H/11H accept/reject, two-bit result
// - Two diagnostics buffers, device owns one
// - Swap command read swaps, changed interrupt confirms
// - Swap sets pending flag, high-priority response
// - Fetch clears flag unless static diagnosis
// - Pending flag readable in status register
// - Owner register: buffer two 3..2, one 1..0
// - Swap read returns device-owned buffer number
// - Host writes byte zero bits 0..7 only
// - Ack not permitted in bus state: not allowed
`timescale 1ns/1ps
`include "scd_cfg.svh"

module scd_cfg_diag_handshake (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cfgTelegramValid,
    input wire scd_pkg::scd_byte_t cfgRxLength,
    input wire logic [3:0] prmTrigCount,
    input wire logic ackAllowed,
    input wire logic newInputBufferCmd,
    input wire logic dataExchTelegram,
    input wire logic diagFetched,
    input wire logic diagSending,
    input wire logic staticDiagBit,
    output scd_pkg::scd_code_t auxBufferPtr,
    output scd_pkg::scd_code_t cfgBufferPtr,
    output scd_pkg::scd_code_t readCfgBufferPtr,
    output scd_pkg::scd_byte_t cfgRxLengthReg,
    output logic newCfgIrq,
    output logic exchangeIrq,
    output logic diagChangedIrq,
    output logic rejectDiagUpdate,
    output logic highPrioResponse,
    output scd_pkg::scd_slave_e slaveState,
    output logic deviceDiagBufTwo
);
    import scd_pkg::*;

    // Bus pipeline
    logic addrValid;
    logic [7:0] addrIdx;
    logic wrPend_q;
    logic [7:0] wrIdx_q;
    logic [31:0] rdData_d;

    // Register file
    scd_byte_t modeOne_q;
    scd_byte_t inLen_q;
    scd_byte_t diag1Len_q;
    scd_byte_t diag2Len_q;

    // Config handshake
    logic cfgPend_q;
    logic cfgConflict_q;
    scd_slave_e slave_q;
    scd_code_t auxPtr_q;
    scd_code_t cfgPtr_q;
    scd_code_t rdCfgPtr_q;
    scd_byte_t rxLen_q;
    logic newCfgIrq_q;
    logic exchIrq_q;
    logic rejDiag_q;

    // Diagnostics
    scd_code_t diag1Own_q;
    scd_code_t diag2Own_q;
    logic swapPend_q;
    logic diagFlag_q;
    logic diagChgIrq_q;
    logic hiPrio_q;
    logic devBufTwo_q;

    logic rdAccept;
    logic rdReject;
    logic rdSwap;
    logic ackAny;
    logic ackOk;
    logic enterDx;
    scd_code_t ackCode;

    // Owner code shown for a buffer; device buffer shows sending while in use
    function automatic scd_code_t shownOwner(input scd_code_t own, input logic sending);
        shownOwner = (own == `SCD_OWN_DEVICE && sending) ? `SCD_OWN_SENDING : own;
    endfunction

    // Code of the buffer the host owns, nil when both sit with the device
    function automatic scd_code_t hostBuffer(input scd_code_t own1, input scd_code_t own2);
        if (own1 == `SCD_OWN_HOST) begin
            hostBuffer = 2'h1;
        end else if (own2 == `SCD_OWN_HOST) begin
            hostBuffer = 2'h2;
        end else begin
            hostBuffer = 2'h0;
        end
    endfunction

    assign addrValid = clkEn && hsel && hready && htrans[1];
    assign addrIdx = haddr[9:2];
    assign rdAccept = addrValid && !hwrite && addrIdx == `SCD_IDX_CFG_ACCEPT;
    assign rdReject = addrValid && !hwrite && addrIdx == `SCD_IDX_CFG_REJECT;
    assign rdSwap = addrValid && !hwrite && addrIdx == `SCD_IDX_DIAG_SWAP;
    assign ackAny = rdAccept || rdReject;
    // No pending event or bus state forbids it: not allowed, nothing moves
    assign ackOk = ackAny && cfgPend_q && ackAllowed && !cfgConflict_q;

    always_comb begin
        if (!ackAny || !cfgPend_q || !ackAllowed) begin
            ackCode = `SCD_ACK_NOT_ALLOWED;
        end else if (cfgConflict_q) begin
            ackCode = `SCD_ACK_CONFLICT;
        end else begin
            ackCode = `SCD_ACK_FINISHED;
        end
    end

    // Empty input buffer and the trigger counter idle allow direct entry
    assign enterDx = (ackOk && rdAccept && inLen_q == `SCD_IN_LEN_EMPTY
                      && prmTrigCount == `SCD_TRIG_ZERO && !cfgTelegramValid)
                     || (clkEn && slave_q == SCD_WAIT_DIN && newInputBufferCmd);

    always_comb begin
        rdData_d = 32'h0000_0000;
        unique case (addrIdx)
            `SCD_IDX_DIAG_OWNER: rdData_d[3:0] = {shownOwner(diag2Own_q, diagSending),
                shownOwner(diag1Own_q, diagSending)};
            `SCD_IDX_DIAG_SWAP: rdData_d[1:0] = diagSending ? `SCD_OWN_NIL
                : hostBuffer(diag2Own_q, diag1Own_q);
            `SCD_IDX_CFG_ACCEPT,
            `SCD_IDX_CFG_REJECT: rdData_d[1:0] = ackCode;
            `SCD_IDX_MODE_ONE: rdData_d[7:0] = modeOne_q;
            `SCD_IDX_STATUS: begin
                rdData_d[`SCD_STAT_DIAG_FLAG_BIT] = diagFlag_q;
                rdData_d[`SCD_STAT_CFG_PEND_BIT] = cfgPend_q;
                rdData_d[`SCD_STAT_STATE_LSB +: 2] = slave_q;
            end
            `SCD_IDX_IN_LEN: rdData_d[7:0] = inLen_q;
            `SCD_IDX_DIAG1_LEN: rdData_d[7:0] = diag1Len_q;
            `SCD_IDX_DIAG2_LEN: rdData_d[7:0] = diag2Len_q;
            default: rdData_d = 32'h0000_0000;
        endcase
    end

    // Read data is formed in the address phase; zero wait states
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            wrPend_q <= 1'b0;
            wrIdx_q <= 8'h00;
        end else if (clkEn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wrPend_q <= addrValid && hwrite;
            wrIdx_q <= addrIdx;
            if (addrValid && !hwrite) begin
                hrdata <= rdData_d;
            end
        end
    end

    // Software registers, written in the data phase; low byte only
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            modeOne_q <= `SCD_RST_MODE_ONE;
            inLen_q <= `SCD_RST_LEN;
            diag1Len_q <= `SCD_RST_LEN;
            diag2Len_q <= `SCD_RST_LEN;
        end else if (clkEn && wrPend_q) begin
            unique case (wrIdx_q)
                `SCD_IDX_MODE_ONE: modeOne_q <= hwdata[7:0];
                `SCD_IDX_IN_LEN: inLen_q <= hwdata[7:0];
                `SCD_IDX_DIAG1_LEN: diag1Len_q <= hwdata[7:0];
                `SCD_IDX_DIAG2_LEN: diag2Len_q <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // Config buffer rotation and handshake; telegram set wins over ack
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            auxPtr_q <= `SCD_RST_AUX_PTR;
            cfgPtr_q <= `SCD_RST_CFG_PTR;
            rdCfgPtr_q <= `SCD_RST_RDCFG_PTR;
            rxLen_q <= `SCD_RST_LEN;
            cfgPend_q <= 1'b0;
            cfgConflict_q <= 1'b0;
            newCfgIrq_q <= 1'b0;
            rejDiag_q <= 1'b0;
        end else if (clkEn) begin
            rejDiag_q <= 1'b0;
            if (ackAny && cfgPend_q && ackAllowed && cfgConflict_q) begin
                cfgConflict_q <= 1'b0;
            end
            if (ackOk) begin
                cfgPend_q <= 1'b0;
                newCfgIrq_q <= 1'b0;
                rejDiag_q <= rdReject;
                if (rdAccept && modeOne_q[`SCD_MODE_CHG_CFG_BIT]) begin
                    cfgPtr_q <= rdCfgPtr_q;
                    rdCfgPtr_q <= cfgPtr_q;
                end
            end
            if (cfgTelegramValid) begin
                // Swap uses the pointer left by any accept in the same cycle
                auxPtr_q <= (ackOk && rdAccept && modeOne_q[`SCD_MODE_CHG_CFG_BIT])
                    ? rdCfgPtr_q : cfgPtr_q;
                cfgPtr_q <= auxPtr_q;
                rxLen_q <= cfgRxLength;
                cfgPend_q <= 1'b1;
                newCfgIrq_q <= 1'b1;
                if (cfgPend_q) begin
                    cfgConflict_q <= 1'b1;
                end
            end
        end
    end

    // Slave state
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            slave_q <= SCD_WAIT_PRM;
            exchIrq_q <= 1'b0;
        end else if (clkEn) begin
            exchIrq_q <= 1'b0;
            if (ackOk && rdReject) begin
                slave_q <= SCD_WAIT_PRM;
            end else if (enterDx && slave_q != SCD_DATA_EXCH) begin
                slave_q <= SCD_DATA_EXCH;
                exchIrq_q <= 1'b1;
            end else if (ackOk && rdAccept) begin
                slave_q <= SCD_WAIT_DIN;
            end else if (cfgTelegramValid && slave_q == SCD_WAIT_PRM) begin
                slave_q <= SCD_WAIT_CFG;
            end
        end
    end

    // Diagnostics ownership; a swap during sending waits for its end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            diag1Own_q <= `SCD_RST_DIAG1_OWNER;
            diag2Own_q <= `SCD_RST_DIAG2_OWNER;
            swapPend_q <= 1'b0;
            diagChgIrq_q <= 1'b0;
            devBufTwo_q <= 1'b1;
        end else if (clkEn) begin
            diagChgIrq_q <= 1'b0;
            if ((rdSwap || swapPend_q) && !diagSending) begin
                diag1Own_q <= diag2Own_q;
                diag2Own_q <= diag1Own_q;
                devBufTwo_q <= (diag1Own_q == `SCD_OWN_DEVICE);
                swapPend_q <= 1'b0;
                diagChgIrq_q <= 1'b1;
            end else if (rdSwap) begin
                swapPend_q <= 1'b1;
            end
        end
    end

    // Pending diagnosis flag; a new swap wins over the fetch clearing it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            diagFlag_q <= 1'b0;
            hiPrio_q <= 1'b0;
        end else if (clkEn) begin
            if (diagChgIrq_q) begin
                diagFlag_q <= 1'b1;
            end else if (diagFetched && !staticDiagBit) begin
                diagFlag_q <= 1'b0;
            end
            if (dataExchTelegram) begin
                hiPrio_q <= diagFlag_q;
            end
        end
    end

    assign auxBufferPtr = auxPtr_q;
    assign cfgBufferPtr = cfgPtr_q;
    assign readCfgBufferPtr = rdCfgPtr_q;
    assign cfgRxLengthReg = rxLen_q;
    assign newCfgIrq = newCfgIrq_q;
    assign exchangeIrq = exchIrq_q;
    assign diagChangedIrq = diagChgIrq_q;
    assign rejectDiagUpdate = rejDiag_q;
    assign highPrioResponse = hiPrio_q;
    assign slaveState = slave_q;
    assign deviceDiagBufTwo = devBufTwo_q;

    telegram_raises_irq_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clkEn && cfgTelegramValid |=> newCfgIrq && cfgBufferPtr == $past(auxPtr_q))
        else $error("config telegram did not swap or interrupt");

    ack_clears_irq_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ackOk && !cfgTelegramValid |=> !newCfgIrq && !cfgPend_q)
        else $error("acknowledgement left config interrupt set");

    reject_to_prm_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ackOk && rdReject |=> slaveState == SCD_WAIT_PRM && rejectDiagUpdate)
        else $error("reject did not return to parameter wait");

    accept_busy_waits_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ackOk && rdAccept && (inLen_q != `SCD_IN_LEN_EMPTY || prmTrigCount != `SCD_TRIG_ZERO)
        && slave_q != SCD_DATA_EXCH && !(slave_q == SCD_WAIT_DIN && newInputBufferCmd)
        |=> slaveState == SCD_WAIT_DIN)
        else $error("accept with input data entered exchange early");

    dx_entry_irq_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $changed(slave_q) && slave_q == SCD_DATA_EXCH |-> exchangeIrq)
        else $error("data exchange entered without interrupt");

    conflict_code_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ackAny && cfgPend_q && ackAllowed && cfgConflict_q
        |=> hrdata[1:0] == `SCD_ACK_CONFLICT)
        else $error("conflict not reported on acknowledgement");

    ack_upper_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ackAny |=> hrdata[31:2] == 30'h0)
        else $error("acknowledgement upper bits not zero");

    not_allowed_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ackAny && !ackAllowed && !cfgTelegramValid
        |=> hrdata[1:0] == `SCD_ACK_NOT_ALLOWED && $stable(cfgPtr_q))
        else $error("forbidden acknowledgement not refused");

    swap_confirm_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rdSwap && !diagSending && !swapPend_q
        |=> diagChangedIrq ##1 (diagFlag_q || !$past(clkEn)))
        else $error("diagnostics swap not confirmed");

    static_holds_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clkEn && diagFlag_q && diagFetched && staticDiagBit |=> diagFlag_q)
        else $error("static diagnosis flag cleared");

    owners_differ_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        diag1Own_q != diag2Own_q)
        else $error("both diagnostics buffers share an owner");

    hi_prio_latch_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clkEn && dataExchTelegram |=> highPrioResponse == $past(diagFlag_q))
        else $error("high-priority response does not follow the flag");

    status_flag_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        addrValid && !hwrite && addrIdx == `SCD_IDX_STATUS
        |=> hrdata[`SCD_STAT_DIAG_FLAG_BIT] == $past(diagFlag_q))
        else $error("status register does not show the pending flag");

    swap_deferred_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rdSwap && diagSending |=> hrdata[1:0] == `SCD_OWN_NIL && $stable(diag1Own_q))
        else $error("swap during sending not deferred");
endmodule

//--- dv/scd_fieldbus_master_model.sv
/*
 * Model of the fieldbus master: config telegrams, exchange telegrams,
 * diagnosis fetches and the sending level. Assumes the bench calls its tasks.
 */
`timescale 1ns/1ps
module scd_fieldbus_master_model (
    input wire logic clk_sys,
    output logic cfgTelegramValid,
    output scd_pkg::scd_byte_t cfgRxLength,
    output logic [3:0] prmTrigCount,
    output logic dataExchTelegram,
    output logic diagFetched,
    output logic diagSending,
    output logic staticDiagBit
);
    import scd_pkg::*;
    initial begin
        {cfgTelegramValid, dataExchTelegram, diagFetched, diagSending, staticDiagBit} = 5'h00;
        cfgRxLength = 8'hA5;
        prmTrigCount = 4'h0;
    end
    task automatic send_cfg(input scd_byte_t len);
        @(posedge clk_sys);
        cfgTelegramValid <= 1'b1;
        cfgRxLength <= len;
        @(posedge clk_sys);
        cfgTelegramValid <= 1'b0;
        cfgRxLength <= ~len; // Stale length inverted, nothing may lean on it
    endtask
    task automatic pulse_exch;
        @(posedge clk_sys);
        dataExchTelegram <= 1'b1;
        @(posedge clk_sys);
        dataExchTelegram <= 1'b0;
    endtask
    task automatic fetch(input logic stat);
        @(posedge clk_sys);
        staticDiagBit <= stat;
        diagFetched <= 1'b1;
        @(posedge clk_sys);
        diagFetched <= 1'b0;
    endtask
    task automatic set_level(input logic [3:0] trig, input logic sending);
        @(posedge clk_sys);
        prmTrigCount <= trig;
        diagSending <= sending;
    endtask
endmodule

//--- dv/tb.sv
/*
 * Self-checking bench: AHB-Lite host tasks, register table rows, then
 * config and diagnostics handshakes. Assumes the fieldbus master model.
 */
`timescale 1ns/1ps
`include "scd_cfg.svh"
module tb;
    import scd_pkg::*;
    typedef struct {logic [7:0] idx; logic [31:0] wd; logic [31:0] exp;} scd_row_s;
    logic clk_sys, sys_rst, hsel, hwrite, ackAllowed, newInputBufferCmd, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic cfgTelegramValid, dataExchTelegram, diagFetched, diagSending, staticDiagBit;
    logic newCfgIrq, exchangeIrq, diagChangedIrq, rejectDiagUpdate, highPrioResponse;
    logic deviceDiagBufTwo, clkEn;
    logic [3:0] prmTrigCount;
    scd_byte_t cfgRxLength, cfgRxLengthReg;
    scd_code_t auxBufferPtr, cfgBufferPtr, readCfgBufferPtr;
    scd_slave_e slaveState;
    int miscompares = 0, checked = 0, exchCnt = 0, rejCnt = 0, chgCnt = 0;
    scd_row_s rows [7] = '{
        '{`SCD_IDX_DIAG1_LEN, 32'h10, 32'h10}, '{`SCD_IDX_DIAG2_LEN, 32'hF3, 32'hF3},
        '{`SCD_IDX_DIAG_OWNER, 32'hFF, 32'({`SCD_OWN_DEVICE, `SCD_OWN_HOST})},
        '{8'h05, 32'hAA, 32'h0}, '{`SCD_IDX_STATUS, 32'hFF, 32'h0},
        '{`SCD_IDX_MODE_ONE, 32'h01, 32'h01}, '{`SCD_IDX_IN_LEN, 32'h00, 32'h00}};

    scd_cfg_diag_handshake scd_cfg_diag_handshake_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cfgTelegramValid(cfgTelegramValid),
        .cfgRxLength(cfgRxLength), .prmTrigCount(prmTrigCount), .ackAllowed(ackAllowed),
        .newInputBufferCmd(newInputBufferCmd), .dataExchTelegram(dataExchTelegram),
        .diagFetched(diagFetched), .diagSending(diagSending), .staticDiagBit(staticDiagBit),
        .auxBufferPtr(auxBufferPtr), .cfgBufferPtr(cfgBufferPtr),
        .readCfgBufferPtr(readCfgBufferPtr), .cfgRxLengthReg(cfgRxLengthReg),
        .newCfgIrq(newCfgIrq), .exchangeIrq(exchangeIrq), .diagChangedIrq(diagChangedIrq),
        .rejectDiagUpdate(rejectDiagUpdate), .highPrioResponse(highPrioResponse),
        .slaveState(slaveState), .deviceDiagBufTwo(deviceDiagBufTwo));
    scd_fieldbus_master_model scd_fieldbus_master_model_inst (.clk_sys(clk_sys),
        .cfgTelegramValid(cfgTelegramValid), .cfgRxLength(cfgRxLength),
        .prmTrigCount(prmTrigCount), .dataExchTelegram(dataExchTelegram),
        .diagFetched(diagFetched), .diagSending(diagSending), .staticDiagBit(staticDiagBit));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Pulses are one cycle wide, so counting beats guessing their exact edge
    always @(posedge clk_sys) begin
        if (exchangeIrq === 1'b1) exchCnt++;
        if (rejectDiagUpdate === 1'b1) rejCnt++;
        if (diagChangedIrq === 1'b1) chgCnt++;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk_sys);
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        hsel <= 1'b1;
        htrans <= 2'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic do_reset;
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        settle(1);
        chk(32'({auxBufferPtr, cfgBufferPtr, readCfgBufferPtr, deviceDiagBufTwo, slaveState}),
            32'({2'h1, 2'h0, 2'h2, 1'b1, SCD_WAIT_PRM}));
        chk({newCfgIrq, highPrioResponse, hreadyout, hresp}, 4'b0010);
    endtask
    task automatic tally_and_finish;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #50000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        {sys_rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 36'h0, 32'h0};
        clkEn = 1'b1;
        {hsize, ackAllowed, newInputBufferCmd} = {3'h2, 2'b10};
        do_reset();
        foreach (rows[i]) begin
            bus(1'b1, rows[i].idx, rows[i].wd);
            bus(1'b0, rows[i].idx, 32'h0);
            chk(rd, rows[i].exp);
        end
        // Trigger counter held nonzero so the accept must wait for input data
        scd_fieldbus_master_model_inst.set_level(4'h1, 1'b0);
        scd_fieldbus_master_model_inst.send_cfg(8'h05);
        settle(1);
        chk({newCfgIrq, slaveState, cfgBufferPtr, auxBufferPtr, cfgRxLengthReg},
            {1'b1, SCD_WAIT_CFG, 2'h1, 2'h0, 8'h05});
        @(posedge clk_sys) ackAllowed <= 1'b0;
        bus(1'b0, `SCD_IDX_CFG_ACCEPT, 32'h0);
        chk(rd, 32'h3);
        chk({newCfgIrq, slaveState}, {1'b1, SCD_WAIT_CFG});
        @(posedge clk_sys) ackAllowed <= 1'b1;
        scd_fieldbus_master_model_inst.send_cfg(8'h07);
        bus(1'b0, `SCD_IDX_CFG_ACCEPT, 32'h0);
        chk(rd, 32'h1);
        settle(1);
        chk({newCfgIrq, slaveState, cfgBufferPtr, auxBufferPtr, cfgRxLengthReg},
            {1'b1, SCD_WAIT_CFG, 2'h0, 2'h1, 8'h07});
        bus(1'b0, `SCD_IDX_CFG_REJECT, 32'h0);
        chk(rd, 32'h0);
        settle(2);
        chk({newCfgIrq, slaveState}, {1'b0, SCD_WAIT_PRM});
        chk(rejCnt, 1);
        bus(1'b0, `SCD_IDX_CFG_REJECT, 32'h0);
        chk(rd, 32'h3);
        settle(2);
        chk({rejCnt[7:0], slaveState, cfgBufferPtr}, {8'h1, SCD_WAIT_PRM, 2'h0});
        scd_fieldbus_master_model_inst.send_cfg(8'h03);
        bus(1'b0, `SCD_IDX_CFG_ACCEPT, 32'h0);
        chk(rd, 32'h0);
        settle(2);
        chk({newCfgIrq, slaveState, cfgBufferPtr, readCfgBufferPtr},
            {1'b0, SCD_WAIT_DIN, 2'h2, 2'h1});
        chk(exchCnt, 0);
        @(posedge clk_sys) newInputBufferCmd <= 1'b1;
        @(posedge clk_sys) newInputBufferCmd <= 1'b0;
        settle(2);
        chk({slaveState, exchCnt[7:0]}, {SCD_DATA_EXCH, 8'h1});
        // Second reset in mid-run; change-config enable now clear
        do_reset();
        scd_fieldbus_master_model_inst.set_level(4'h0, 1'b0);
        scd_fieldbus_master_model_inst.send_cfg(8'h02);
        // No parameter event pending, so the config ack stands alone
        bus(1'b0, `SCD_IDX_CFG_ACCEPT, 32'h0);
        settle(2);
        chk({slaveState, cfgBufferPtr, readCfgBufferPtr}, {SCD_DATA_EXCH, 2'h1, 2'h2});
        chk(exchCnt, 2);
        bus(1'b0, `SCD_IDX_STATUS, 32'h0);
        chk(rd, 32'h0C);
        // Diagnostics buffer swap and pending flag
        bus(1'b0, `SCD_IDX_DIAG_SWAP, 32'h0);
        chk(rd, 32'h2);
        settle(2);
        chk({deviceDiagBufTwo, chgCnt[7:0]}, {1'b0, 8'h1});
        bus(1'b0, `SCD_IDX_DIAG_OWNER, 32'h0);
        chk(rd, 32'({`SCD_OWN_HOST, `SCD_OWN_DEVICE}));
        bus(1'b0, `SCD_IDX_STATUS, 32'h0);
        chk(rd, 32'h0D);
        scd_fieldbus_master_model_inst.pulse_exch();
        settle(1);
        chk(highPrioResponse, 1'b1);
        scd_fieldbus_master_model_inst.fetch(1'b1);
        bus(1'b0, `SCD_IDX_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        scd_fieldbus_master_model_inst.fetch(1'b0);
        bus(1'b0, `SCD_IDX_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h0);
        scd_fieldbus_master_model_inst.pulse_exch();
        settle(1);
        chk(highPrioResponse, 1'b0);
        // Swap requested while the device buffer is on the wire is held off
        scd_fieldbus_master_model_inst.set_level(4'h0, 1'b1);
        bus(1'b0, `SCD_IDX_DIAG_SWAP, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, `SCD_IDX_DIAG_OWNER, 32'h0);
        chk(rd & 32'h3, 32'({`SCD_OWN_SENDING}));
        chk({deviceDiagBufTwo, chgCnt[7:0]}, {1'b0, 8'h1});
        scd_fieldbus_master_model_inst.set_level(4'h0, 1'b0);
        settle(4);
        chk({deviceDiagBufTwo, chgCnt[7:0]}, {1'b1, 8'h2});
        // Frozen clock enable: a telegram in that cycle is not taken
        @(posedge clk_sys) clkEn <= 1'b0;
        scd_fieldbus_master_model_inst.send_cfg(8'h09);
        clkEn <= 1'b1;
        settle(1);
        chk({newCfgIrq, slaveState, cfgRxLengthReg}, {1'b0, SCD_DATA_EXCH, 8'h02});
        tally_and_finish();
    end
endmodule
